// ===== hw/frt_defs.svh
// Constants for the free-running timer with input capture.
// Assumes inclusion by bare name from the package and design files.
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH

// Register offsets, word addressed on a 4-bit address port
`define FRT_ADDR_CTRL 4'h0
`define FRT_ADDR_COUNT 4'h1
`define FRT_ADDR_EDGE 4'h2
`define FRT_ADDR_IRQ_STAT 4'h3
`define FRT_ADDR_IRQ_CLR 4'h4
`define FRT_ADDR_IRQ_EN 4'h5
`define FRT_ADDR_AUTO_SEL 4'h6
`define FRT_ADDR_CAP0 4'h8

// Control register fields
`define FRT_CTRL_DIV_LSB 0
`define FRT_CTRL_STOP_BIT 2
`define FRT_CTRL_CLR_BIT 3

// Interrupt status layout: bit 0 overflow, bits 4..1 captures
`define FRT_IRQ_OVF_BIT 0
`define FRT_IRQ_W 5

// Overflow request number
`define FRT_OVF_IRQ_NUM 8'h13

// Prescaler division exponents for the four ratios
`define FRT_DIV_SEL0 4'd1
`define FRT_DIV_SEL1 4'd2
`define FRT_DIV_SEL2 4'd3
`define FRT_DIV_SEL3 4'd4

// Reset values
`define FRT_COUNT_RST 16'h0000
`define FRT_CTRL_RST 3'h0

`endif

// ===== hw/frt_pkg.sv
// Types shared by the free-running timer and its capture channels.
// Assumes frt_defs.svh is on the include path.
`include "frt_defs.svh"

package frt_pkg;

  typedef enum logic [1:0] {
    FRT_EDGE_NONE,
    FRT_EDGE_RISE,
    FRT_EDGE_FALL,
    FRT_EDGE_BOTH
  } frt_edge_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } frt_bus_req_t;

  typedef struct packed {
    logic irq;
    logic [`FRT_IRQ_W-1:0] auto_req;
  } frt_irq_out_t;

endpackage : frt_pkg

// ===== hw/frt_prescaler.sv
// Prescaler: divides the machine clock into a one-cycle count tick.
// Assumes one clock, reset already synchronised by the parent.
`timescale 1ns/1ps
`default_nettype none
`include "frt_defs.svh"

module frt_prescaler #(
  parameter int unsigned DIV_W = 4
) (
  input wire logic clk_sys_i, // Machine clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic run_i, // Counting enabled
  input wire logic [1:0] div_sel_i, // Division ratio select
  output logic tick_o // Count clock enable
);
  import frt_pkg::*;

  // Elaboration check on the divider width
  if (DIV_W < 4)
  begin : g_bad_div_w
    $error("frt_prescaler: DIV_W too small for the largest ratio");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] mask;

  function automatic logic [DIV_W-1:0] div_mask(input logic [1:0] sel);
    logic [3:0] sh;
    sh = `FRT_DIV_SEL0;
    case (sel)
      2'd0: sh = `FRT_DIV_SEL0;
      2'd1: sh = `FRT_DIV_SEL1;
      2'd2: sh = `FRT_DIV_SEL2;
      default: sh = `FRT_DIV_SEL3;
    endcase
    div_mask = DIV_W'((1 << sh) - 1);
  endfunction : div_mask

  always_comb
  begin
    mask = div_mask(div_sel_i);
    cnt_d = cnt_q;
    if (!run_i)
      cnt_d = '0;
    else
      cnt_d = DIV_W'(cnt_q + 1'b1);
  end

  assign tick_o = run_i && ((cnt_q & mask) == mask);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule : frt_prescaler
`default_nettype wire

// ===== hw/frt_capture_ch.sv
// One capture channel: edge detect on a pin and latch of the count.
// Assumes the pin is already synchronous to the machine clock.
`timescale 1ns/1ps
`default_nettype none
`include "frt_defs.svh"

module frt_capture_ch #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_sys_i, // Machine clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic pin_i, // Capture input pin
  input wire frt_pkg::frt_edge_t edge_sel_i, // Edge choice
  input wire logic [CNT_W-1:0] count_i, // Shared time base
  output logic event_o, // One-cycle capture pulse
  output logic [CNT_W-1:0] data_o // Captured count
);
  import frt_pkg::*;

  logic pin_q;
  logic pin_d;
  logic [CNT_W-1:0] data_q;
  logic [CNT_W-1:0] data_d;
  logic rise;
  logic fall;
  logic hit;

  always_comb
  begin
    rise = pin_i && !pin_q;
    fall = !pin_i && pin_q;
    case (edge_sel_i)
      FRT_EDGE_RISE: hit = rise;
      FRT_EDGE_FALL: hit = fall;
      FRT_EDGE_BOTH: hit = rise || fall;
      default: hit = 1'b0;
    endcase
    pin_d = pin_i;
    data_d = hit ? count_i : data_q;
  end

  assign event_o = hit;
  assign data_o = data_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_q <= 1'b0;
      data_q <= '0;
    end
    else
    begin
      pin_q <= pin_d;
      data_q <= data_d;
    end
  end

endmodule : frt_capture_ch
`default_nettype wire

// ===== hw/frt_timer_top.sv
// Free-running 16-bit timer with four capture channels and interrupts.
// Assumes a synchronous register port and capture pins synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "frt_defs.svh"

module frt_timer_top #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned N_UNIT = 2,
  parameter int unsigned PINS_PER_UNIT = 2
) (
  input wire logic clk_sys_i, // Machine clock, 100 MHz
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [3:0] reg_addr_i, // Register word address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
  input wire logic [N_UNIT*PINS_PER_UNIT-1:0] cap_pin_i, // Capture pins
  output logic irq_o, // Level interrupt
  output logic [7:0] ovf_irq_num_o, // Overflow request number
  output logic [`FRT_IRQ_W-1:0] auto_io_req_o, // Auto transfer starts
  output logic [CNT_W-1:0] count_o // Count, registered copy one cycle behind the counter
);
  import frt_pkg::*;

  localparam int unsigned NCH = N_UNIT * PINS_PER_UNIT;

  // Elaboration checks on the parameters
  if (CNT_W != 16)
  begin : g_bad_cnt_w
    $error("frt_timer_top: counter width must be 16");
  end
  if (NCH != `FRT_IRQ_W - 1)
  begin : g_bad_nch
    $error("frt_timer_top: status layout serves four channels");
  end

  //////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////
  // Register port
  frt_bus_req_t bus;
  assign bus.addr = reg_addr_i;
  assign bus.wdata = reg_wdata_i;
  assign bus.wr = reg_wr_i;
  assign bus.rd = reg_rd_i;

  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic [2*NCH-1:0] edge_q;
  logic [2*NCH-1:0] edge_d;
  logic [`FRT_IRQ_W-1:0] stat_q;
  logic [`FRT_IRQ_W-1:0] stat_d;
  logic [`FRT_IRQ_W-1:0] en_q;
  logic [`FRT_IRQ_W-1:0] en_d;
  logic [`FRT_IRQ_W-1:0] auto_q;
  logic [`FRT_IRQ_W-1:0] auto_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic [`FRT_IRQ_W-1:0] auto_req_q;
  logic [`FRT_IRQ_W-1:0] auto_req_d;
  logic [CNT_W-1:0] count_out_q;

  logic tick;
  logic running;
  logic [NCH-1:0] cap_ev;
  logic [CNT_W-1:0] cap_data [NCH];
  logic [`FRT_IRQ_W-1:0] events;
  frt_irq_out_t irq_next;

  function automatic logic hit(input frt_bus_req_t b, input logic [3:0] a);
    hit = (b.addr == a);
  endfunction : hit

  function automatic logic [31:0] zext_cnt(input logic [CNT_W-1:0] val);
    zext_cnt = {{(32 - CNT_W){1'b0}}, val};
  endfunction : zext_cnt

  assign running = !ctrl_q[`FRT_CTRL_STOP_BIT];

  //////////////////////////////////////////////////////////////////////
  // Prescaler
  frt_prescaler #(
    .DIV_W(4)
  ) u_presc (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .run_i(running),
    .div_sel_i(ctrl_q[`FRT_CTRL_DIV_LSB +: 2]),
    .tick_o(tick)
  );

  //////////////////////////////////////////////////////////////////////
  // Capture channels, grouped as units of pins
  genvar gu;
  genvar gp;
  generate
    for (gu = 0; gu < N_UNIT; gu++)
    begin : g_unit
      for (gp = 0; gp < PINS_PER_UNIT; gp++)
      begin : g_pin
        // Channel index runs unit by unit
        localparam int unsigned CH = gu * PINS_PER_UNIT + gp;
        frt_capture_ch #(
          .CNT_W(CNT_W)
        ) u_ch (
          .clk_sys_i(clk_sys_i),
          .rst_n_i(rst_n),
          .pin_i(cap_pin_i[CH]),
          .edge_sel_i(frt_edge_t'(edge_q[2*CH +: 2])),
          .count_i(cnt_q),
          .event_o(cap_ev[CH]),
          .data_o(cap_data[CH])
        );
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Counter
  logic ovf;

  always_comb
  begin
    ovf = 1'b0;
    cnt_d = cnt_q;
    if (bus.wr && hit(bus, `FRT_ADDR_CTRL) && bus.wdata[`FRT_CTRL_CLR_BIT])
      cnt_d = `FRT_COUNT_RST;
    else if (bus.wr && hit(bus, `FRT_ADDR_COUNT) && !running)
      cnt_d = bus.wdata[CNT_W-1:0];
    else if (tick)
    begin
      cnt_d = CNT_W'(cnt_q + 1'b1);
      ovf = (cnt_q == {CNT_W{1'b1}});
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= `FRT_COUNT_RST;
    else
      cnt_q <= cnt_d;
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_comb
  begin
    ctrl_d = ctrl_q;
    edge_d = edge_q;
    en_d = en_q;
    auto_d = auto_q;
    // Clear bit acts once and is not stored
    if (bus.wr && hit(bus, `FRT_ADDR_CTRL))
      ctrl_d = bus.wdata[2:0];
    if (bus.wr && hit(bus, `FRT_ADDR_EDGE))
      edge_d = bus.wdata[2*NCH-1:0];
    if (bus.wr && hit(bus, `FRT_ADDR_IRQ_EN))
      en_d = bus.wdata[`FRT_IRQ_W-1:0];
    if (bus.wr && hit(bus, `FRT_ADDR_AUTO_SEL))
      auto_d = bus.wdata[`FRT_IRQ_W-1:0];
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `FRT_CTRL_RST;
      edge_q <= '0;
      en_q <= '0;
      auto_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      edge_q <= edge_d;
      en_q <= en_d;
      auto_q <= auto_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sticky status and request outputs
  always_comb
  begin
    events = {cap_ev, ovf};
    stat_d = stat_q;
    if (bus.wr && hit(bus, `FRT_ADDR_IRQ_CLR))
      stat_d = stat_q & ~bus.wdata[`FRT_IRQ_W-1:0];
    // Set wins over a clear in the same cycle
    stat_d = stat_d | events;
    irq_next.irq = |(stat_q & en_q & ~auto_q);
    irq_next.auto_req = stat_q & en_q & auto_q;
    irq_d = irq_next.irq;
    auto_req_d = irq_next.auto_req;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_q <= '0;
      irq_q <= 1'b0;
      auto_req_q <= '0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q <= irq_d;
      auto_req_q <= auto_req_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read path and registered count copy
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (bus.rd)
    begin
      if (hit(bus, `FRT_ADDR_CTRL))
        rdata_d = {29'h0, ctrl_q};
      else if (hit(bus, `FRT_ADDR_COUNT))
        rdata_d = zext_cnt(cnt_q);
      else if (hit(bus, `FRT_ADDR_EDGE))
        rdata_d = {{(32 - 2*NCH){1'b0}}, edge_q};
      else if (hit(bus, `FRT_ADDR_IRQ_STAT))
        rdata_d = {27'h0, stat_q};
      else if (hit(bus, `FRT_ADDR_IRQ_EN))
        rdata_d = {27'h0, en_q};
      else if (hit(bus, `FRT_ADDR_AUTO_SEL))
        rdata_d = {27'h0, auto_q};
      else if (bus.addr[3] && (bus.addr[2:0] < 3'(NCH)))
        rdata_d = zext_cnt(cap_data[bus.addr[1:0]]);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0000_0000;
      count_out_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
      count_out_q <= cnt_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  logic [7:0] irq_num_q;

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_num_q <= `FRT_OVF_IRQ_NUM;
    else
      irq_num_q <= `FRT_OVF_IRQ_NUM;
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign ovf_irq_num_o = irq_num_q;
  assign auto_io_req_o = auto_req_q;
  assign count_o = count_out_q;

endmodule : frt_timer_top
`default_nettype wire

// ===== verif/frt_timer_assertions.sv
// Checker on the timer's ports: register reads, count steps, requests.
// Assumes binding to every frt_timer_top instance.
`timescale 1ns/1ps
`default_nettype none
`include "frt_defs.svh"

module frt_timer_assertions #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned N_UNIT = 2,
  parameter int unsigned PINS_PER_UNIT = 2
) (
  input wire logic clk_sys_i, // Clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic [3:0] reg_addr_i, // Address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [31:0] reg_rdata_o, // Read data
  input wire logic [N_UNIT*PINS_PER_UNIT-1:0] cap_pin_i, // Pins
  input wire logic irq_o, // Interrupt
  input wire logic [7:0] ovf_irq_num_o, // Request number
  input wire logic [`FRT_IRQ_W-1:0] auto_io_req_o, // Auto requests
  input wire logic [CNT_W-1:0] count_o // Count
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  ////////////////////////////////////////
  a_irq_number: assert property (ovf_irq_num_o == 8'h13)
    else $error("overflow request number wrong");
  a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside read cycle");
  a_count_read: assert property (reg_rd_i && reg_addr_i == 4'h1 |=>
    reg_rdata_o[CNT_W-1:0] == count_o) else $error("count read mismatch");
  a_count_step: assert property ($changed(count_o) && !$past(reg_wr_i, 2) |->
    count_o == CNT_W'($past(count_o) + 1'b1)) else $error("count step wrong");
  a_tick_gap: assert property ($changed(count_o) && !$past(reg_wr_i, 2) |=>
    $stable(count_o) || $past(reg_wr_i, 2)) else $error("tick faster than half rate");
  a_irq_fall: assert property ($fell(irq_o) |->
    $past(reg_wr_i, 2) || $past(reg_wr_i, 3)) else $error("interrupt dropped alone");
  a_irq_rise: assert property ($rose(irq_o) |-> $past(reg_wr_i, 2) ||
    $past(reg_wr_i, 3) || count_o == '0 || $past(cap_pin_i, 2) != $past(cap_pin_i, 3))
    else $error("interrupt without cause");
  a_auto_fall: assert property (|($past(auto_io_req_o) & ~auto_io_req_o) |->
    $past(reg_wr_i, 2) || $past(reg_wr_i, 3)) else $error("auto request dropped alone");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i >= 4'hc |=>
    reg_rdata_o == 32'h0) else $error("unmapped read not zero");

  c_irq: cover property ($rose(irq_o));
  c_auto: cover property ($rose(|auto_io_req_o));
  c_wrap: cover property (count_o == '0 && $past(count_o) == {CNT_W{1'b1}});
endmodule : frt_timer_assertions

bind frt_timer_top frt_timer_assertions #(.CNT_W(CNT_W), .N_UNIT(N_UNIT),
  .PINS_PER_UNIT(PINS_PER_UNIT)) frt_timer_assertions_inst (.clk_sys_i, .rst_b_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cap_pin_i, .irq_o,
  .ovf_irq_num_o, .auto_io_req_o, .count_o);
`default_nettype wire

// ===== verif/frt_pin_src.sv
// Signal sources on the four capture pins.
// Assumes one clock; pins change only just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module frt_pin_src (
  input wire logic clk_sys_i, // Clock
  output logic [3:0] pin_o // Capture pins
);
  initial pin_o = 4'h0;

  // New levels after lag edges, prompt when lag is 0
  task automatic drive(input logic [3:0] lvl, input int lag);
    repeat (lag) @(posedge clk_sys_i);
    pin_o <= lvl;
  endtask : drive
endmodule : frt_pin_src
`default_nettype wire

// ===== verif/frt_timer_tb_top.sv
// Bench for the timer: reset values, division, overflow, capture.
// Assumes design, checker and pin source compiled before it.
`timescale 1ns/1ps
`default_nettype none

module frt_timer_tb_top;
  import frt_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0] pins;
  logic irq;
  logic [7:0] irq_num;
  logic [4:0] auto_req;
  logic [15:0] count;
  logic [31:0] v;
  logic [31:0] e;
  logic [31:0] ce [4] = '{32'h100, 32'h200, 32'h200, 32'h0};
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  frt_timer_top frt_timer_top_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .cap_pin_i(pins), .irq_o(irq), .ovf_irq_num_o(irq_num),
    .auto_io_req_o(auto_req), .count_o(count));
  frt_pin_src frt_pin_src_inst (.clk_sys_i(clk_sys_i), .pin_o(pins));

  initial forever #5 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk($sformatf("reg %h", a), v, exp);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : settle

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_chk(4'h3, 32'h0);
    rd_chk(4'h5, 32'h0);
    rd_chk(4'hf, 32'h0);
    chk("num", 32'(irq_num), 32'h13);
    wr_reg(4'h0, 32'hc);
    rd_chk(4'h1, 32'h0);
    wr_reg(4'h1, 32'hfffd);
    rd_chk(4'h1, 32'hfffd);
    // Overflow routed to auto transfer first, then to the interrupt
    wr_reg(4'h5, 32'h1f);
    wr_reg(4'h6, 32'h1);
    wr_reg(4'h0, 32'h0);
    repeat (12) @(posedge clk_sys_i);
    wr_reg(4'h0, 32'h4);
    settle(1);
    chk("auto", 32'(auto_req), 32'h1);
    chk("irq", 32'(irq), 32'h0);
    rd_chk(4'h3, 32'h1);
    wr_reg(4'h6, 32'h0);
    settle(2);
    chk("irq", 32'(irq), 32'h1);
    chk("auto", 32'(auto_req), 32'h0);
    wr_reg(4'h4, 32'h1);
    settle(2);
    chk("irq", 32'(irq), 32'h0);
    // Count write while running is ignored
    wr_reg(4'h0, 32'h8);
    wr_reg(4'h1, 32'h8000);
    wr_reg(4'h0, 32'h4);
    rd_reg(4'h1);
    chk("load", 32'(v < 32'h100), 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(4'h0, 32'hc);
      wr_reg(4'h0, 32'(s));
      repeat (62) @(posedge clk_sys_i);
      wr_reg(4'h0, 32'h4);
      rd_reg(4'h1);
      e = 32'(64 >> (s + 1));
      chk("div", v, e);
    end
    // Captures on a halted count
    wr_reg(4'h1, 32'h100);
    wr_reg(4'h2, 32'({FRT_EDGE_NONE, FRT_EDGE_BOTH, FRT_EDGE_FALL, FRT_EDGE_RISE}));
    frt_pin_src_inst.drive(4'hf, 0);
    settle(4);
    rd_chk(4'h3, 32'ha);
    chk("irq", 32'(irq), 32'h1);
    wr_reg(4'h1, 32'h200);
    frt_pin_src_inst.drive(4'h0, 5);
    settle(4);
    chk("count_o", 32'(count), 32'h200);
    rd_chk(4'h3, 32'he);
    wr_reg(4'h3, 32'h0);
    rd_chk(4'h3, 32'he);
    for (int i = 0; i < 4; i++)
      rd_chk(4'(8 + i), ce[i]);
    // Channel 0 routed to auto transfer, the rest stay on the interrupt
    wr_reg(4'h6, 32'h2);
    settle(2);
    chk("auto", 32'(auto_req), 32'h2);
    chk("irq", 32'(irq), 32'h1);
    wr_reg(4'h4, 32'h1f);
    settle(2);
    chk("irq", 32'(irq), 32'h0);
    chk("auto", 32'(auto_req), 32'h0);
    rd_chk(4'h3, 32'h0);
    give_verdict();
  end
endmodule : frt_timer_tb_top
`default_nettype wire
